// >>> core/lpcv_top.sv
// What this block does
// [R1] Sleep code picks sleep time (2^k+1)*256 clocks, k from 3..33, reset 010.
// [R2] Sleep code matters only with low power on, trigger mode off; use codes >= 4.
// [R3] Settle code picks wake-to-calibration wait (2^k+1)*256 clocks, reset 01.
// [R4] Settle wait applies whenever low power is on; software avoids code 0.
// [R5] Trigger mode bit 0: timer ends sleep; bit 1: cores sleep until triggered.
// [R6] In trigger mode a sleeping core wakes while the chosen trigger is low.
// [R7] Low power enable resets 0 and works only with background calibration on.
// [R8] Port enable bit 0 must be set before vector port reads or writes work.
// [R9] Each enabled vector port read returns next byte; full vector is 673 reads.
// [R10] Each enabled vector port write loads the next vector byte; 673 writes restore.
// [R11] Host uses address hold and streaming so bytes hit one port address.
// [R12] Host touches vector port only while calibration halted status reads 1.
// [R13] Stopping before 673 accesses leaves vector invalid; host completes the count.
// [R14] Channel A gain trim holds factory value after reset, readable and writable.
// [R15] Halted status follows background stop, or foreground done when background off.
// [R16] Trigger select 0 uses software trigger bit, 1 uses external trigger input.
// [R17] Channel B gain trim holds factory value after reset, readable and writable.
// [R18] Vector index restarts on fresh port enable and advances once per access.
// [R19] Sleep and settle timers restart per core episode; cores calibrate in turn.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module lpcv_top #(
	parameter int NUM_CORES = 4,
	parameter int UNIT_CYCLES = lpcv_pkg::INTERVAL_UNIT,
	parameter int EXP_REDUCE = 0,
	parameter logic [7:0] GAIN_A_FACTORY = 8'h80,
	parameter logic [7:0] GAIN_B_FACTORY = 8'h80
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Avalon-MM slave
	input wire logic [8:0] address_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [31:0] writedata_in,
	input wire logic [3:0] byteenable_in,
	output logic [31:0] readdata_out,
	output logic waitrequest_out,
	// Calibration engine
	input wire logic external_cal_trigger_in,
	input wire logic bg_stopped_in,
	input wire logic fg_done_in,
	input wire logic core_cal_done_in,
	output logic [NUM_CORES-1:0] core_sleep_out,
	output logic [NUM_CORES-1:0] core_cal_req_out,
	output logic [7:0] gain_a_out,
	output logic [7:0] gain_b_out
);
	localparam int CW = (NUM_CORES > 1) ? $clog2(NUM_CORES) : 1;

	logic [7:0] sched_reg;
	logic [7:0] port_en_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] gain_a_reg;
	logic [7:0] gain_b_reg;
	logic ack_reg;
	logic [7:0] rd_byte_reg;
	logic vec_sel_reg;
	logic [lpcv_pkg::VEC_AW-1:0] idx_reg;
	logic vec_done_reg;
	logic port_en_prev_reg;
	logic [lpcv_pkg::TIMER_W-1:0] timer_reg;
	logic [CW-1:0] core_reg;
	logic [CW-1:0] core_next;
	lpcv_pkg::lpcv_state_type state_reg;
	lpcv_pkg::lpcv_state_type state_next;
	logic [NUM_CORES-1:0] sleep_reg;
	logic [NUM_CORES-1:0] calreq_reg;
	logic request;
	logic complete;
	logic [6:0] idx_addr;
	logic bus_wr;
	logic vec_access;
	logic port_on;
	logic [7:0] mem_q;
	logic mem_we;
	logic lp_active;
	logic trig_mode;
	logic trig_level;
	logic halted;
	logic load_sleep;
	logic load_settle;
	logic [5:0] sleep_k;
	logic [5:0] settle_k;
	logic [lpcv_pkg::TIMER_W-1:0] sleep_count;
	logic [lpcv_pkg::TIMER_W-1:0] settle_count;

	// Bus handshake: every request is answered one cycle after it is seen
	assign request = read_in | write_in;
	assign waitrequest_out = request & ~ack_reg;
	assign complete = request & ack_reg;
	assign idx_addr = address_in[8:2];
	assign bus_wr = complete & write_in & byteenable_in[0];
	assign port_on = port_en_reg[0];
	assign vec_access = complete & (idx_addr == lpcv_pkg::VEC_PORT_IDX) & port_on; // [R8]
	assign readdata_out = {24'h000000, vec_sel_reg ? mem_q : rd_byte_reg};

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			ack_reg <= 1'b0;
		else
			ack_reg <= request & ~ack_reg;
	end

	// Halted status and trigger selection
	assign halted = ctrl_reg[lpcv_pkg::BG_EN_BIT] ? bg_stopped_in : fg_done_in; // [R15]
	assign trig_level = ctrl_reg[lpcv_pkg::TRIG_SEL_BIT] ? external_cal_trigger_in
		: ctrl_reg[lpcv_pkg::SOFT_TRIG_BIT]; // [R16]
	assign lp_active = sched_reg[lpcv_pkg::LOW_POWER_CAL_ENABLE_BIT] & ctrl_reg[lpcv_pkg::BG_EN_BIT]; // [R7]
	assign trig_mode = sched_reg[lpcv_pkg::WAKE_TRIG_BIT];

	// Read data capture, one cycle ahead of the answer
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rd_byte_reg <= 8'h00;
			vec_sel_reg <= 1'b0;
		end
		else
		begin
			vec_sel_reg <= (idx_addr == lpcv_pkg::VEC_PORT_IDX) & port_on;
			case (idx_addr)
				lpcv_pkg::CTRL_IDX: rd_byte_reg <= ctrl_reg;
				lpcv_pkg::STATUS_IDX: rd_byte_reg <= {5'h00, lp_active, vec_done_reg, halted};
				lpcv_pkg::SCHED_IDX: rd_byte_reg <= sched_reg;
				lpcv_pkg::PORT_EN_IDX: rd_byte_reg <= port_en_reg;
				lpcv_pkg::GAIN_A_IDX: rd_byte_reg <= gain_a_reg; // [R14]
				lpcv_pkg::GAIN_B_IDX: rd_byte_reg <= gain_b_reg; // [R17]
				default: rd_byte_reg <= 8'h00;
			endcase
		end
	end

	// Software registers
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			sched_reg <= lpcv_pkg::SCHED_RESET; // [R1] [R3]
			port_en_reg <= lpcv_pkg::PORT_EN_RESET;
			ctrl_reg <= lpcv_pkg::CTRL_RESET;
		end
		else if (bus_wr)
		begin
			if (idx_addr == lpcv_pkg::SCHED_IDX)
				sched_reg <= writedata_in[7:0];
			if (idx_addr == lpcv_pkg::PORT_EN_IDX)
				port_en_reg <= writedata_in[7:0];
			if (idx_addr == lpcv_pkg::CTRL_IDX)
				ctrl_reg <= {5'h00, writedata_in[2:0]};
		end
	end

	// Gain trims start at their factory values
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			gain_a_reg <= GAIN_A_FACTORY; // [R14]
			gain_b_reg <= GAIN_B_FACTORY; // [R17]
		end
		else if (bus_wr)
		begin
			if (idx_addr == lpcv_pkg::GAIN_A_IDX)
				gain_a_reg <= writedata_in[7:0]; // [R14]
			if (idx_addr == lpcv_pkg::GAIN_B_IDX)
				gain_b_reg <= writedata_in[7:0]; // [R17]
		end
	end
	assign gain_a_out = gain_a_reg;
	assign gain_b_out = gain_b_reg;

	// Vector index: restarts on a fresh enable, steps per access, wraps after last byte
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			idx_reg <= '0;
			port_en_prev_reg <= 1'b0;
			vec_done_reg <= 1'b0;
		end
		else
		begin
			port_en_prev_reg <= port_on;
			if (port_on && !port_en_prev_reg)
			begin
				idx_reg <= '0; // [R18]
				vec_done_reg <= 1'b0; // [R13]
			end
			else if (vec_access)
			begin
				if (idx_reg == lpcv_pkg::VEC_LAST)
				begin
					idx_reg <= '0;
					vec_done_reg <= 1'b1; // [R13]
				end
				else
					idx_reg <= idx_reg + 1'b1; // [R9] [R10] [R18]
			end
		end
	end

	assign mem_we = vec_access & write_in & byteenable_in[0]; // [R10]

	lpcv_vec_mem #(
		.DEPTH(lpcv_pkg::VEC_LEN),
		.WIDTH(8),
		.AW(lpcv_pkg::VEC_AW)
	) u_vec_mem (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.write_en_in(mem_we),
		.addr_in(idx_reg),
		.wdata_in(writedata_in[7:0]),
		.rdata_out(mem_q)
	);

	// Interval lengths from the codes
	always_comb
	begin
		sleep_k = lpcv_pkg::SLEEP_EXP[sched_reg[7:5]];
		settle_k = lpcv_pkg::SETTLE_EXP[sched_reg[4:3]];
		if (int'(sleep_k) > EXP_REDUCE)
			sleep_k = 6'(int'(sleep_k) - EXP_REDUCE);
		else
			sleep_k = 6'h00;
		if (int'(settle_k) > EXP_REDUCE)
			settle_k = 6'(int'(settle_k) - EXP_REDUCE);
		else
			settle_k = 6'h00;
	end
	assign sleep_count = lpcv_pkg::TIMER_W'(((42'h1 << sleep_k) + 42'h1)
		* 42'(UNIT_CYCLES)); // [R1]
	assign settle_count = lpcv_pkg::TIMER_W'(((42'h1 << settle_k) + 42'h1)
		* 42'(UNIT_CYCLES)); // [R3]

	// Sleep, settle and calibrate each core in turn
	always_comb
	begin
		state_next = state_reg;
		core_next = core_reg;
		load_sleep = 1'b0;
		load_settle = 1'b0;
		if (!lp_active)
			state_next = lpcv_pkg::LP_IDLE; // [R7]
		else
		begin
			case (state_reg)
				lpcv_pkg::LP_IDLE:
				begin
					state_next = lpcv_pkg::LP_SLEEP;
					load_sleep = 1'b1;
				end
				lpcv_pkg::LP_SLEEP:
				begin
					if (trig_mode ? !trig_level : (timer_reg == '0)) // [R5] [R6]
					begin
						state_next = lpcv_pkg::LP_SETTLE;
						load_settle = 1'b1; // [R3]
					end
				end
				lpcv_pkg::LP_SETTLE:
				begin
					if (timer_reg == '0)
						state_next = lpcv_pkg::LP_CAL;
				end
				lpcv_pkg::LP_CAL:
				begin
					if (core_cal_done_in)
					begin
						state_next = lpcv_pkg::LP_SLEEP;
						load_sleep = 1'b1; // [R19]
						if (int'(core_reg) == NUM_CORES - 1)
							core_next = '0;
						else
							core_next = core_reg + 1'b1; // [R19]
					end
				end
				default: state_next = lpcv_pkg::LP_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_reg <= lpcv_pkg::LP_IDLE;
			core_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			core_reg <= core_next;
		end
	end

	// Interval timer, reloaded at every episode
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			timer_reg <= '0;
		else if (load_sleep)
			timer_reg <= sleep_count - 1'b1; // [R1] [R19]
		else if (load_settle)
			timer_reg <= settle_count - 1'b1; // [R3] [R19]
		else if (timer_reg != '0)
			timer_reg <= timer_reg - 1'b1;
	end

	// Per-core sleep and calibration requests
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CORES; gi++)
		begin : g_core
			always_ff @(posedge clk_in or negedge arst_n_in)
			begin
				if (!arst_n_in)
				begin
					sleep_reg[gi] <= 1'b0;
					calreq_reg[gi] <= 1'b0;
				end
				else
				begin
					sleep_reg[gi] <= (state_next == lpcv_pkg::LP_SLEEP) && (int'(core_next) == gi);
					calreq_reg[gi] <= (state_next == lpcv_pkg::LP_CAL) && (int'(core_next) == gi);
				end
			end
		end
	endgenerate
	assign core_sleep_out = sleep_reg;
	assign core_cal_req_out = calreq_reg;

	// Checks
	bus_answer_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(request && waitrequest_out) |=> (!waitrequest_out || !request))
		else $error("bus request not answered in one cycle");
	idx_restart_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R18]
		(port_on && !port_en_prev_reg) |=> (idx_reg == '0))
		else $error("vector index did not restart");
	idx_step_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R9]
		(vec_access && idx_reg != lpcv_pkg::VEC_LAST && port_en_prev_reg)
		|=> (idx_reg == $past(idx_reg) + 1'b1))
		else $error("vector index did not advance");
	port_gate_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R8]
		(complete && !port_on && port_en_prev_reg == port_on) |=> $stable(idx_reg))
		else $error("disabled port moved the index");
	wake_trig_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R6]
		(state_reg == lpcv_pkg::LP_SLEEP && lp_active && trig_mode && !trig_level)
		|=> (state_reg == lpcv_pkg::LP_SETTLE))
		else $error("core did not wake on low trigger");
	auto_sleep_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R5]
		(state_reg == lpcv_pkg::LP_SLEEP && lp_active && !trig_mode && timer_reg != '0)
		|=> (state_reg == lpcv_pkg::LP_SLEEP))
		else $error("core woke before sleep time");
	sleep_load_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R1]
		load_sleep |=> (timer_reg == $past(sleep_count) - 1'b1))
		else $error("sleep timer loaded wrong");
	settle_load_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R3]
		load_settle |=> (timer_reg == $past(settle_count) - 1'b1) ##1 !sleep_reg[core_reg])
		else $error("settle timer loaded wrong");
	lp_gate_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R7]
		!lp_active |=> (state_reg == lpcv_pkg::LP_IDLE) ##1 (sleep_reg == '0 || lp_active))
		else $error("low power ran while disabled");
	gain_write_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R14]
		(bus_wr && idx_addr == lpcv_pkg::GAIN_A_IDX)
		|=> (gain_a_out == $past(writedata_in[7:0])))
		else $error("gain trim A write lost");
endmodule // lpcv_top
`default_nettype wire

// >>> pkg/lpcv_pkg.sv
`default_nettype none
package lpcv_pkg;
	// Register indices; byte address on the bus is four times the index
	localparam logic [6:0] CTRL_IDX = 7'h60;
	localparam logic [6:0] STATUS_IDX = 7'h61;
	localparam logic [6:0] SCHED_IDX = 7'h6e;
	localparam logic [6:0] PORT_EN_IDX = 7'h70;
	localparam logic [6:0] VEC_PORT_IDX = 7'h71;
	localparam logic [6:0] GAIN_A_IDX = 7'h7a;
	localparam logic [6:0] GAIN_B_IDX = 7'h7b;
	// Reset values
	localparam logic [7:0] SCHED_RESET = 8'h48;
	localparam logic [7:0] PORT_EN_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h04;
	// Schedule register fields
	localparam int SLEEP_CODE_LSB = 5;
	localparam int SETTLE_CODE_LSB = 3;
	localparam int WAKE_TRIG_BIT = 1;
	localparam int LOW_POWER_CAL_ENABLE_BIT = 0;
	// Control register fields
	localparam int BG_EN_BIT = 0;
	localparam int TRIG_SEL_BIT = 1;
	localparam int SOFT_TRIG_BIT = 2;
	// Status register fields
	localparam int HALTED_BIT = 0;
	localparam int VEC_DONE_BIT = 1;
	localparam int LP_ACTIVE_BIT = 2;
	// Calibration vector
	localparam int VEC_LEN = 673;
	localparam int VEC_AW = 10;
	localparam logic [9:0] VEC_LAST = 10'h2a0;
	// Interval exponents, per code
	localparam logic [5:0] SLEEP_EXP [8] = '{6'h03, 6'h0f, 6'h12, 6'h15,
		6'h18, 6'h1b, 6'h1e, 6'h21};
	localparam logic [5:0] SETTLE_EXP [4] = '{6'h03, 6'h12, 6'h15, 6'h18};
	localparam int INTERVAL_UNIT = 256;
	localparam int TIMER_W = 42;
	typedef enum {LP_IDLE, LP_SLEEP, LP_SETTLE, LP_CAL} lpcv_state_type;
endpackage
`default_nettype wire

// >>> core/lpcv_vec_mem.sv
`timescale 1ns/1ns
`default_nettype none
module lpcv_vec_mem #(
	parameter int DEPTH = 673,
	parameter int WIDTH = 8,
	parameter int AW = 10
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Single port
	input wire logic write_en_in,
	input wire logic [AW-1:0] addr_in,
	input wire logic [WIDTH-1:0] wdata_in,
	output logic [WIDTH-1:0] rdata_out
);
	logic [WIDTH-1:0] mem_reg [DEPTH];

	always_ff @(posedge clk_in)
	begin
		if (write_en_in && (int'(addr_in) < DEPTH))
			mem_reg[addr_in] <= wdata_in;
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			rdata_out <= '0;
		else if (int'(addr_in) < DEPTH)
			rdata_out <= mem_reg[addr_in];
		else
			rdata_out <= '0;
	end
endmodule // lpcv_vec_mem
`default_nettype wire

// >>> bench/lpcv_host.sv
`timescale 1ns/1ns
`default_nettype none
module lpcv_host (
	// Clock
	input wire logic clk_in,
	// Avalon-MM master
	output logic [8:0] address_out,
	output logic read_out,
	output logic write_out,
	output logic [31:0] writedata_out,
	output logic [3:0] byteenable_out,
	input wire logic [31:0] readdata_in,
	input wire logic waitrequest_in
);
	initial
	begin
		address_out = 9'h000;
		read_out = 1'b0;
		write_out = 1'b0;
		writedata_out = 32'h0;
		byteenable_out = 4'h1;
	end
	// Request held until waitrequest low; upper data and enables are noise
	task automatic xfer(input logic [6:0] idx, input logic wr, input logic [7:0] wd,
		output logic [31:0] rd);
		@(posedge clk_in);
		address_out <= {idx, 2'b00};
		read_out <= ~wr;
		write_out <= wr;
		writedata_out <= {24'($urandom()), wd};
		byteenable_out <= {3'($urandom()), 1'b1};
		do
			@(posedge clk_in);
		while (waitrequest_in !== 1'b0);
		rd = readdata_in;
		read_out <= 1'b0;
		write_out <= 1'b0;
	endtask
endmodule // lpcv_host
`default_nettype wire

// >>> bench/lpcv_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module lpcv_top_test;
	localparam int RED = 15;
	localparam int SLP = (1 << (24 - RED)) + 1;
	localparam int STL = (1 << (18 - RED)) + 1;
	logic clk_in;
	logic arst_n_in;
	logic [8:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [3:0] byteenable;
	logic [31:0] readdata;
	logic waitrequest;
	logic ext_trig;
	logic bg_stopped;
	logic fg_done;
	logic core_done;
	logic [3:0] core_sleep;
	logic [3:0] core_req;
	logic [7:0] gain_a;
	logic [7:0] gain_b;
	int num_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic [7:0] b;
	logic [7:0] vec_q [$];

	lpcv_top #(.UNIT_CYCLES(1), .EXP_REDUCE(RED)) u_lpcv_top (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .address_in(address),
		.read_in(read), .write_in(write), .writedata_in(writedata),
		.byteenable_in(byteenable), .readdata_out(readdata), .waitrequest_out(waitrequest),
		.external_cal_trigger_in(ext_trig), .bg_stopped_in(bg_stopped),
		.fg_done_in(fg_done), .core_cal_done_in(core_done), .core_sleep_out(core_sleep),
		.core_cal_req_out(core_req), .gain_a_out(gain_a), .gain_b_out(gain_b)
	);
	lpcv_host u_lpcv_host (
		.clk_in(clk_in), .address_out(address), .read_out(read), .write_out(write),
		.writedata_out(writedata), .byteenable_out(byteenable), .readdata_in(readdata),
		.waitrequest_in(waitrequest)
	);

	initial
	begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end

	task automatic end_sim();
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles > 30000)
		begin
			chk("timeout", 32'h0, 32'h1);
			end_sim();
		end
	end

	task automatic wr(input logic [6:0] idx, input logic [7:0] d);
		logic [31:0] unused;
		u_lpcv_host.xfer(idx, 1'b1, d, unused);
	endtask

	task automatic rd_chk(input string name, input logic [6:0] idx, input logic [31:0] exp,
		input logic [31:0] mask = 32'hffffffff);
		u_lpcv_host.xfer(idx, 1'b0, 8'h00, rd);
		chk(name, exp, rd & mask);
	endtask

	// Calibration request must appear on the expected core near the expected time
	task automatic wait_req(input int core, input int lo);
		int n;
		n = 0;
		while (core_req === 4'h0 && n < lo + 8)
		begin
			@(negedge clk_in);
			n++;
		end
		chk("req_delay_ok", 32'h1, {31'h0, n >= lo - 2 && n < lo + 8});
		chk("req_core", 32'(1 << core), {28'h0, core_req});
	endtask

	task automatic finish_core();
		int n;
		n = 0;
		@(posedge clk_in);
		core_done <= 1'b1;
		while (core_req !== 4'h0 && n < 8)
		begin
			@(negedge clk_in);
			n++;
		end
		chk("req_drop", 32'h0, {28'h0, core_req});
		@(posedge clk_in);
		core_done <= 1'b0;
	endtask

	// Only the expected cores sleep and no core is calibrated during the window
	task automatic quiet(input int n, input logic [3:0] sleep_exp);
		logic [7:0] acc;
		acc = 8'h00;
		repeat (n)
		begin
			@(negedge clk_in);
			acc = acc | ({core_sleep, core_req} ^ {sleep_exp, 4'h0});
		end
		chk("quiet", 32'h0, {24'h0, acc});
	endtask

	initial
	begin
		void'($urandom(59));
		arst_n_in = 1'b0;
		ext_trig = 1'b1;
		bg_stopped = 1'b0;
		fg_done = 1'b1;
		core_done = 1'b0;
		repeat (16) @(posedge clk_in);
		arst_n_in <= 1'b1;
		rd_chk("sched", 7'h6e, 32'h48);
		rd_chk("port_en", 7'h70, 32'h0);
		rd_chk("gain_a", 7'h7a, 32'h80);
		rd_chk("gain_b", 7'h7b, 32'h80);
		rd_chk("ctrl", 7'h60, 32'h4);
		b = 8'($urandom());
		wr(7'h7a, b);
		wr(7'h7b, ~b);
		rd_chk("gain_a_rw", 7'h7a, {24'h0, b});
		rd_chk("gain_b_rw", 7'h7b, {24'h0, ~b});
		chk("gain_pins", {16'h0, b, ~b}, {16'h0, gain_a, gain_b});
		wr(7'h55, 8'ha5);
		rd_chk("unmapped", 7'h55, 32'h0);
		rd_chk("halted_fg", 7'h61, 32'h1, 32'h1);
		fg_done <= 1'b0;
		rd_chk("halted_fg0", 7'h61, 32'h0, 32'h1);
		wr(7'h60, 8'h05);
		rd_chk("halted_bg0", 7'h61, 32'h0, 32'h1);
		bg_stopped <= 1'b1;
		rd_chk("halted_bg1", 7'h61, 32'h1, 32'h1);
		wr(7'h71, 8'h3c);
		rd_chk("vec_off", 7'h71, 32'h0);
		wr(7'h70, 8'h01);
		for (int i = 0; i < 673; i++)
		begin
			vec_q.push_back(8'($urandom()));
			wr(7'h71, vec_q[i]);
		end
		rd_chk("vec_done", 7'h61, 32'h2, 32'h2);
		wr(7'h70, 8'h00);
		wr(7'h70, 8'h01);
		rd_chk("vec_rst", 7'h61, 32'h0, 32'h2);
		foreach (vec_q[i])
			rd_chk("vec_byte", 7'h71, {24'h0, vec_q[i]});
		// Low power with background off, then autonomous rounds over all cores
		wr(7'h60, 8'h04);
		wr(7'h6e, 8'h89);
		rd_chk("lp_idle", 7'h61, 32'h0, 32'h4);
		quiet(SLP + STL + 20, 4'h0);
		wr(7'h60, 8'h05);
		for (int c = 0; c < 4; c++)
		begin
			wait_req(c, SLP + STL);
			finish_core();
		end
		// Trigger mode, external source then software source
		wr(7'h6e, 8'h00);
		wr(7'h60, 8'h07);
		wr(7'h6e, 8'h8b);
		rd_chk("lp_active", 7'h61, 32'h4, 32'h4);
		quiet(SLP + 40, 4'h1);
		@(posedge clk_in);
		ext_trig <= 1'b0;
		wait_req(0, STL);
		@(posedge clk_in);
		ext_trig <= 1'b1;
		finish_core();
		wr(7'h60, 8'h05);
		ext_trig <= 1'b0;
		quiet(40, 4'h2);
		wr(7'h60, 8'h01);
		wait_req(1, STL);
		finish_core();
		end_sim();
	end
endmodule // lpcv_top_test
`default_nettype wire
